// >>> accel_ctrl_pkg.sv
package accel_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SYS_CTRL_ONE_ADDR = 8'h2a;
  localparam logic [7:0] SYS_CTRL_TWO_ADDR = 8'h2b;
  // Axis data registers, high byte first per axis
  localparam logic [7:0] OUT_X_HIGH_ADDR = 8'h01;
  localparam logic [7:0] OUT_Y_HIGH_ADDR = 8'h03;
  localparam logic [7:0] OUT_Z_HIGH_ADDR = 8'h05;
  localparam logic [7:0] OUT_Z_LOW_ADDR = 8'h06;

  // ----------------------------------------------------------------
  // Field positions, system control one
  // ----------------------------------------------------------------
  localparam int SLEEP_RATE_LSB = 6;
  localparam int WAKE_RATE_LSB = 3;
  localparam int LOW_NOISE_BIT = 2;
  localparam int FAST_READ_BIT = 1;
  localparam int ACTIVE_BIT = 0;

  // ----------------------------------------------------------------
  // Field positions, system control two
  // ----------------------------------------------------------------
  localparam int SELF_TEST_BIT = 7;
  localparam int SOFT_RESET_BIT = 6;
  localparam int UNUSED_BIT = 5;
  localparam int SLEEP_SCHEME_LSB = 3;
  localparam int AUTO_SLEEP_BIT = 2;
  localparam int WAKE_SCHEME_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SLEEP_RATE_RESET = 2'h0;
  localparam logic [2:0] WAKE_RATE_RESET = 3'h0;
  localparam logic [1:0] SCHEME_RESET = 2'h0;
  localparam logic [1:0] FIFO_MODE_OFF = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int BASE_PERIOD_NS = 1250000;
  localparam int BASE_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BOOT_CYCLES = 16;

  // ----------------------------------------------------------------
  // Power schemes and operating states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCHEME_NORMAL = 2'h0,
    SCHEME_LOW_NOISE_LOW_POWER = 2'h1,
    SCHEME_HIGH_RES = 2'h2,
    SCHEME_LOW_POWER = 2'h3
  } power_scheme_t;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'h1,
    ST_WAKE = 3'h2,
    ST_SLEEP = 3'h4
  } op_state_t;

endpackage

// >>> accel_system_control_regs.sv
`timescale 1ns/10ps
module accel_system_control_regs
  import accel_ctrl_pkg::*;
#(
  parameter int BASE_COUNT = BASE_CYCLES,
  parameter int BOOT_COUNT = BOOT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [1:0] fifo_operating_mode,
  input wire logic sleep_request,
  input wire logic wake_event,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  output logic [7:0] next_read_addr,
  output logic serial_reset,
  output logic boot_busy,
  output logic active_mode,
  output logic sleeping,
  output logic [2:0] output_sample_rate,
  output logic sample_tick,
  output logic [1:0] power_scheme,
  output logic [10:0] os_ratio,
  output logic range_limit_4g,
  output logic self_test_enable,
  output logic fast_read,
  output logic fifo_skip_low
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0] sleep_sample_rate;
  logic [2:0] wake_rate_select;
  logic low_noise_select;
  logic fast_read_sel;
  logic active_sel;
  logic self_test_sel;
  logic [1:0] sleep_oversample_scheme;
  logic auto_sleep_enable;
  logic [1:0] wake_oversample_scheme;
  logic [$clog2(BOOT_COUNT + 1)-1:0] boot_cnt;
  op_state_t state;

  logic [1:0] next_sleep_sample_rate;
  logic [2:0] next_wake_rate_select;
  logic next_low_noise_select;
  logic next_fast_read_sel;
  logic next_active_sel;
  logic next_self_test_sel;
  logic [1:0] next_sleep_oversample_scheme;
  logic next_auto_sleep_enable;
  logic [1:0] next_wake_oversample_scheme;
  logic [$clog2(BOOT_COUNT + 1)-1:0] next_boot_cnt;
  op_state_t next_state;

  logic in_boot;
  logic wr_one;
  logic wr_two;
  logic soft_reset_req;

  assign in_boot = (boot_cnt != '0);
  // Writes are dropped while the serial side is held in reset
  assign wr_one = reg_wr && !in_boot && (reg_addr == SYS_CTRL_ONE_ADDR);
  assign wr_two = reg_wr && !in_boot && (reg_addr == SYS_CTRL_TWO_ADDR);
  assign soft_reset_req = wr_two && reg_wdata[SOFT_RESET_BIT];

  always_comb begin
    next_sleep_sample_rate = sleep_sample_rate;
    next_wake_rate_select = wake_rate_select;
    next_low_noise_select = low_noise_select;
    next_fast_read_sel = fast_read_sel;
    next_active_sel = active_sel;
    next_self_test_sel = self_test_sel;
    next_sleep_oversample_scheme = sleep_oversample_scheme;
    next_auto_sleep_enable = auto_sleep_enable;
    next_wake_oversample_scheme = wake_oversample_scheme;
    next_boot_cnt = in_boot ? boot_cnt - 1'b1 : boot_cnt;
    next_state = state;
    if (soft_reset_req) begin
      next_sleep_sample_rate = SLEEP_RATE_RESET;
      next_wake_rate_select = WAKE_RATE_RESET;
      next_low_noise_select = 1'b0;
      next_fast_read_sel = 1'b0;
      next_active_sel = 1'b0;
      next_self_test_sel = 1'b0;
      next_sleep_oversample_scheme = SCHEME_RESET;
      next_auto_sleep_enable = 1'b0;
      next_wake_oversample_scheme = SCHEME_RESET;
      next_boot_cnt = ($bits(boot_cnt))'(BOOT_COUNT);
      next_state = ST_STANDBY;
    end else begin
      if (wr_one) begin
        next_sleep_sample_rate = reg_wdata[SLEEP_RATE_LSB +: 2];
        next_wake_rate_select = reg_wdata[WAKE_RATE_LSB +: 3];
        next_low_noise_select = reg_wdata[LOW_NOISE_BIT];
        next_active_sel = reg_wdata[ACTIVE_BIT];
        // Fast read held unless the FIFO is off
        if (fifo_operating_mode == FIFO_MODE_OFF) begin
          next_fast_read_sel = reg_wdata[FAST_READ_BIT];
        end
      end
      if (wr_two) begin
        next_self_test_sel = reg_wdata[SELF_TEST_BIT];
        next_sleep_oversample_scheme = reg_wdata[SLEEP_SCHEME_LSB +: 2];
        next_auto_sleep_enable = reg_wdata[AUTO_SLEEP_BIT];
        next_wake_oversample_scheme = reg_wdata[WAKE_SCHEME_LSB +: 2];
      end
      case (state)
        ST_STANDBY: begin
          if (active_sel) begin
            next_state = ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (!active_sel) begin
            next_state = ST_STANDBY;
          end else if (auto_sleep_enable && sleep_request) begin
            next_state = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!active_sel) begin
            next_state = ST_STANDBY;
          end else if (!auto_sleep_enable || wake_event) begin
            next_state = ST_WAKE;
          end
        end
        default: next_state = ST_STANDBY;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sleep_sample_rate <= SLEEP_RATE_RESET;
      wake_rate_select <= WAKE_RATE_RESET;
      low_noise_select <= 1'b0;
      fast_read_sel <= 1'b0;
      active_sel <= 1'b0;
      self_test_sel <= 1'b0;
      sleep_oversample_scheme <= SCHEME_RESET;
      auto_sleep_enable <= 1'b0;
      wake_oversample_scheme <= SCHEME_RESET;
      boot_cnt <= '0;
      state <= ST_STANDBY;
    end else begin
      sleep_sample_rate <= next_sleep_sample_rate;
      wake_rate_select <= next_wake_rate_select;
      low_noise_select <= next_low_noise_select;
      fast_read_sel <= next_fast_read_sel;
      active_sel <= next_active_sel;
      self_test_sel <= next_self_test_sel;
      sleep_oversample_scheme <= next_sleep_oversample_scheme;
      auto_sleep_enable <= next_auto_sleep_enable;
      wake_oversample_scheme <= next_wake_oversample_scheme;
      boot_cnt <= next_boot_cnt;
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Effective rate, scheme and read side
  // ----------------------------------------------------------------
  logic [2:0] eff_rate;
  logic [1:0] eff_scheme;
  logic [10:0] ratio_lut;
  logic [7:0] next_rdata;
  logic next_hit;
  logic [7:0] next_ptr;

  // Sleep codes map onto the four slowest wake codes
  assign eff_rate = (state == ST_SLEEP) ? {1'b1, sleep_sample_rate} :
                    wake_rate_select;
  assign eff_scheme = (state == ST_SLEEP) ? sleep_oversample_scheme :
                      wake_oversample_scheme;

  os_ratio_lookup u_ratio (
    .rate_code(eff_rate),
    .scheme(eff_scheme),
    .ratio(ratio_lut)
  );

  sample_tick_gen #(
    .BASE_COUNT(BASE_COUNT)
  ) u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(state != ST_STANDBY),
    .rate_code(eff_rate),
    .tick(sample_tick)
  );

  always_comb begin
    next_rdata = 8'h00;
    next_hit = 1'b0;
    next_ptr = reg_addr + 8'h01;
    if (reg_addr == SYS_CTRL_ONE_ADDR) begin
      next_hit = 1'b1;
      next_rdata = {sleep_sample_rate, wake_rate_select, low_noise_select,
                    fast_read_sel, active_sel};
    end else if (reg_addr == SYS_CTRL_TWO_ADDR) begin
      next_hit = 1'b1;
      // Soft reset and bit 5 always read as zero
      next_rdata = {self_test_sel, 1'b0, 1'b0, sleep_oversample_scheme,
                    auto_sleep_enable, wake_oversample_scheme};
    end
    if (fast_read_sel) begin
      if (reg_addr == OUT_X_HIGH_ADDR || reg_addr == OUT_Y_HIGH_ADDR ||
          reg_addr == OUT_Z_HIGH_ADDR) begin
        next_ptr = reg_addr + 8'h02;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || in_boot) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
      next_read_addr <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
      reg_hit <= next_hit;
      next_read_addr <= next_ptr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      serial_reset <= 1'b0;
      boot_busy <= 1'b0;
      active_mode <= 1'b0;
      sleeping <= 1'b0;
      output_sample_rate <= WAKE_RATE_RESET;
      power_scheme <= SCHEME_RESET;
      os_ratio <= 11'h002;
      range_limit_4g <= 1'b0;
      self_test_enable <= 1'b0;
      fast_read <= 1'b0;
      fifo_skip_low <= 1'b0;
    end else begin
      serial_reset <= (next_boot_cnt != '0);
      boot_busy <= (next_boot_cnt != '0);
      active_mode <= (next_state != ST_STANDBY);
      sleeping <= (next_state == ST_SLEEP);
      output_sample_rate <= eff_rate;
      power_scheme <= eff_scheme;
      os_ratio <= ratio_lut;
      range_limit_4g <= next_low_noise_select;
      self_test_enable <= next_self_test_sel;
      fast_read <= next_fast_read_sel;
      fifo_skip_low <= next_fast_read_sel;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_soft_reset_write;
    reg_wr && !in_boot && reg_addr == SYS_CTRL_TWO_ADDR &&
      reg_wdata[SOFT_RESET_BIT];
  endsequence

  sequence s_reset_cleared;
    !active_mode && !self_test_enable && !fast_read && !range_limit_4g;
  endsequence

  a_soft_reset_defaults: assert property (
    s_soft_reset_write |=> s_reset_cleared)
    else $error("soft reset did not restore defaults");
  a_serial_reset_hold: assert property (
    s_soft_reset_write |=> serial_reset && boot_busy &&
      boot_cnt == BOOT_COUNT)
    else $error("serial reset not held during boot");
  a_rst_bit_reads_zero: assert property (
    reg_rd && reg_addr == SYS_CTRL_TWO_ADDR && !in_boot |=>
      !reg_rdata[SOFT_RESET_BIT] && !reg_rdata[UNUSED_BIT])
    else $error("reset or unused bit read as one");
  a_sleep_rate_override: assert property (
    sleeping |=> output_sample_rate == {1'b1, $past(sleep_sample_rate)})
    else $error("sleep rate not applied in sleep");
  a_no_sleep_disabled: assert property (
    !auto_sleep_enable && !sleeping |=> !sleeping)
    else $error("entered sleep with auto-sleep off");
  a_standby_when_off: assert property (
    !active_sel && !soft_reset_req |=> !active_mode)
    else $error("active while mode bit is clear");
  a_fast_read_guard: assert property (
    reg_wr && reg_addr == SYS_CTRL_ONE_ADDR && !in_boot &&
      fifo_operating_mode != FIFO_MODE_OFF |=> $stable(fast_read_sel))
    else $error("fast read changed with FIFO running");
  a_pointer_skip: assert property (
    reg_rd && !in_boot && fast_read_sel && reg_addr == OUT_X_HIGH_ADDR |=>
      next_read_addr == 8'h03)
    else $error("fast read pointer did not skip low byte");
  a_ratio_fastest: assert property (
    output_sample_rate == 3'h0 && !sleeping |-> os_ratio == 11'h002)
    else $error("ratio at fastest rate is not two");
  a_low_noise_follow: assert property (
    wr_one && !soft_reset_req |=> range_limit_4g == $past(reg_wdata[2]))
    else $error("range limit does not follow low noise bit");

endmodule // accel_system_control_regs

// >>> host_port_model.sv
`timescale 1ns/10ps
module host_port_model (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  output logic [1:0] fifo_operating_mode
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    fifo_operating_mode = 2'h0;
  end

  // ----------------------------------------------------------------
  // Register port cycles, launched and released on the falling edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    // Released lines show a changed value, never the stale one
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  // Fast read is only meant to change with the FIFO off
  task automatic set_fifo(input logic [1:0] m);
    @(negedge ref_clk);
    fifo_operating_mode = m;
  endtask
endmodule // host_port_model

// >>> os_ratio_lookup.sv
`timescale 1ns/10ps
module os_ratio_lookup
  import accel_ctrl_pkg::*;
(
  input wire logic [2:0] rate_code,
  input wire logic [1:0] scheme,
  output logic [10:0] ratio
);
  logic [3:0] shift;

  // Ratio held as a power of two, rows run from the fastest rate
  always_comb begin
    shift = 4'h1;
    case (scheme)
      SCHEME_NORMAL: begin
        case (rate_code)
          3'h0: shift = 4'h1;
          3'h5: shift = 4'h4;
          3'h6: shift = 4'h5;
          3'h7: shift = 4'h7;
          default: shift = 4'h2;
        endcase
      end
      SCHEME_LOW_NOISE_LOW_POWER: begin
        case (rate_code)
          3'h0: shift = 4'h1;
          3'h6: shift = 4'h3;
          3'h7: shift = 4'h5;
          default: shift = 4'h2;
        endcase
      end
      SCHEME_HIGH_RES: begin
        case (rate_code)
          3'h0: shift = 4'h1;
          3'h1: shift = 4'h2;
          3'h2: shift = 4'h3;
          3'h3: shift = 4'h4;
          3'h4: shift = 4'h5;
          3'h5: shift = 4'h7;
          3'h6: shift = 4'h8;
          default: shift = 4'ha;
        endcase
      end
      default: begin
        case (rate_code)
          3'h6: shift = 4'h2;
          3'h7: shift = 4'h4;
          default: shift = 4'h1;
        endcase
      end
    endcase
    ratio = 11'h001 << shift;
  end
endmodule // os_ratio_lookup

// >>> sample_tick_gen.sv
`timescale 1ns/10ps
module sample_tick_gen
  import accel_ctrl_pkg::*;
#(
  parameter int BASE_COUNT = BASE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [2:0] rate_code,
  output logic tick
);
  localparam int BW = $clog2(BASE_COUNT + 1);

  logic [BW-1:0] base_cnt;
  logic [9:0] unit_cnt;
  logic [9:0] units;
  logic [BW-1:0] next_base_cnt;
  logic [9:0] next_unit_cnt;
  logic next_tick;

  // Period in steps of the fastest sample period
  always_comb begin
    case (rate_code)
      3'h0: units = 10'h001;
      3'h1: units = 10'h002;
      3'h2: units = 10'h004;
      3'h3: units = 10'h008;
      3'h4: units = 10'h010;
      3'h5: units = 10'h040;
      3'h6: units = 10'h080;
      default: units = 10'h200;
    endcase
  end

  always_comb begin
    next_base_cnt = base_cnt + 1'b1;
    next_unit_cnt = unit_cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_base_cnt = '0;
      next_unit_cnt = '0;
    end else if (base_cnt == BW'(BASE_COUNT - 1)) begin
      next_base_cnt = '0;
      next_unit_cnt = unit_cnt + 10'h001;
      if (unit_cnt >= units - 10'h001) begin
        next_unit_cnt = '0;
        next_tick = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      base_cnt <= '0;
      unit_cnt <= '0;
      tick <= 1'b0;
    end else begin
      base_cnt <= next_base_cnt;
      unit_cnt <= next_unit_cnt;
      tick <= next_tick;
    end
  end
endmodule // sample_tick_gen

// >>> tb_accel_system_control_regs.sv
`timescale 1ns/10ps
module tb_accel_system_control_regs;
  import accel_ctrl_pkg::*;
  localparam int BC = 4;
  localparam int BT = 4;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic sleep_request = 1'b0;
  logic wake_event = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, next_read_addr, d;
  logic reg_wr, reg_rd, reg_hit, serial_reset, boot_busy;
  logic active_mode, sleeping, sample_tick, range_limit_4g;
  logic self_test_enable, fast_read, fifo_skip_low;
  logic [1:0] fifo_operating_mode, power_scheme;
  logic [2:0] output_sample_rate;
  logic [10:0] os_ratio;
  int n_errors = 0;
  int n_tests = 0;
  int gap;
  int rt [4][8] = '{'{2, 4, 4, 4, 4, 16, 32, 128},
                    '{2, 4, 4, 4, 4, 4, 8, 32},
                    '{2, 4, 8, 16, 32, 128, 256, 1024},
                    '{2, 2, 2, 2, 2, 2, 4, 16}};
  int units [8] = '{1, 2, 4, 8, 16, 64, 128, 512};

  always #10 ref_clk = ~ref_clk;

  host_port_model host (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .fifo_operating_mode(fifo_operating_mode));

  accel_system_control_regs #(.BASE_COUNT(BC), .BOOT_COUNT(BT)) DUT (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .fifo_operating_mode(fifo_operating_mode),
    .sleep_request(sleep_request), .wake_event(wake_event),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .next_read_addr(next_read_addr), .serial_reset(serial_reset),
    .boot_busy(boot_busy), .active_mode(active_mode),
    .sleeping(sleeping), .output_sample_rate(output_sample_rate),
    .sample_tick(sample_tick), .power_scheme(power_scheme),
    .os_ratio(os_ratio), .range_limit_4g(range_limit_4g),
    .self_test_enable(self_test_enable), .fast_read(fast_read),
    .fifo_skip_low(fifo_skip_low));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [10:0] e,
                     input logic [10:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Cycles between the first and second tick seen after the task starts
  task automatic tick_gap(output int n);
    int k;
    n = 0;
    for (k = 0; k < 2; k++) begin
      n = 0;
      @(negedge ref_clk);
      while (sample_tick !== 1'b1 && n < 3000) begin
        n++;
        @(negedge ref_clk);
      end
    end
    n++;
  endtask

  task final_report;
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    cyc(40000);
    n_errors++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(20);
    srst = 1'b0;
    host.rd(SYS_CTRL_ONE_ADDR, d);
    chk("ctrl_one", 11'(8'h00), 11'(d));
    chk("ctrl_hit", 11'(1'b1), 11'(reg_hit));
    host.rd(SYS_CTRL_TWO_ADDR, d);
    chk("ctrl_two", 11'(8'h00), 11'(d));
    chk("active", 11'(1'b0), 11'(active_mode));
    chk("os_ratio", 11'(2), os_ratio);
    for (int r = 0; r < 8; r++) begin
      host.wr(SYS_CTRL_ONE_ADDR, 8'((r << 3) | 1));
      for (int s = 0; s < 4; s++) begin
        host.wr(SYS_CTRL_TWO_ADDR, 8'(s));
        cyc(3);
        chk("rate", 11'(r), 11'(output_sample_rate));
        chk("scheme", 11'(s), 11'(power_scheme));
        chk("os_ratio", 11'(rt[s][r]), os_ratio);
      end
      tick_gap(gap);
      chk("tick_gap", 11'(BC * units[r]), 11'(gap));
    end
    chk("active", 11'(1'b1), 11'(active_mode));
    host.wr(SYS_CTRL_ONE_ADDR, 8'h00);
    cyc(3);
    chk("active", 11'(1'b0), 11'(active_mode));
    // Config bits, fast read pointer and refused fast read change
    host.wr(SYS_CTRL_ONE_ADDR, 8'h06);
    chk("range_4g", 11'(1'b1), 11'(range_limit_4g));
    chk("fast_read", 11'(1'b1), 11'(fast_read));
    chk("fifo_skip", 11'(1'b1), 11'(fifo_skip_low));
    host.rd(OUT_X_HIGH_ADDR, d);
    chk("ptr_x", 11'(8'h03), 11'(next_read_addr));
    chk("hit_x", 11'(1'b0), 11'(reg_hit));
    host.rd(OUT_Z_HIGH_ADDR, d);
    chk("ptr_z", 11'(8'h07), 11'(next_read_addr));
    host.rd(OUT_Z_LOW_ADDR, d);
    chk("ptr_zl", 11'(8'h07), 11'(next_read_addr));
    host.set_fifo(2'h1);
    host.wr(SYS_CTRL_ONE_ADDR, 8'h04);
    host.rd(SYS_CTRL_ONE_ADDR, d);
    chk("ctrl_one", 11'(8'h06), 11'(d));
    host.set_fifo(2'h0);
    host.wr(SYS_CTRL_ONE_ADDR, 8'h00);
    chk("fast_read", 11'(1'b0), 11'(fast_read));
    host.rd(OUT_X_HIGH_ADDR, d);
    chk("ptr_x", 11'(8'h02), 11'(next_read_addr));
    // Self-test and unused bit
    host.wr(SYS_CTRL_TWO_ADDR, 8'hbf);
    host.rd(SYS_CTRL_TWO_ADDR, d);
    chk("ctrl_two", 11'(8'h9f), 11'(d));
    chk("self_test", 11'(1'b1), 11'(self_test_enable));
    // Auto-sleep entry, sleep rates, wake-up, and sleep disabled
    host.wr(SYS_CTRL_TWO_ADDR, 8'h15);
    host.wr(SYS_CTRL_ONE_ADDR, 8'h01);
    @(negedge ref_clk);
    sleep_request = 1'b1;
    cyc(3);
    chk("sleeping", 11'(1'b1), 11'(sleeping));
    chk("scheme", 11'(2), 11'(power_scheme));
    for (int s = 0; s < 4; s++) begin
      host.wr(SYS_CTRL_ONE_ADDR, 8'((s << 6) | 1));
      cyc(3);
      chk("sleep_rate", 11'(4 + s), 11'(output_sample_rate));
      chk("os_ratio", 11'(rt[2][4 + s]), os_ratio);
    end
    chk("active", 11'(1'b1), 11'(active_mode));
    sleep_request = 1'b0;
    wake_event = 1'b1;
    @(negedge ref_clk);
    wake_event = 1'b0;
    cyc(3);
    chk("sleeping", 11'(1'b0), 11'(sleeping));
    chk("rate", 11'(0), 11'(output_sample_rate));
    chk("scheme", 11'(1), 11'(power_scheme));
    sleep_request = 1'b1;
    cyc(3);
    chk("sleeping", 11'(1'b1), 11'(sleeping));
    // Clearing auto-sleep while asleep must fall back to wake
    host.wr(SYS_CTRL_TWO_ADDR, 8'h11);
    cyc(2);
    chk("sleeping", 11'(1'b0), 11'(sleeping));
    cyc(6);
    chk("sleeping", 11'(1'b0), 11'(sleeping));
    chk("active", 11'(1'b1), 11'(active_mode));
    sleep_request = 1'b0;
    // Soft reset while active, write refused during boot
    host.wr(SYS_CTRL_TWO_ADDR, 8'hc0);
    chk("boot_busy", 11'(1'b1), 11'(boot_busy));
    chk("serial_rst", 11'(1'b1), 11'(serial_reset));
    chk("active", 11'(1'b0), 11'(active_mode));
    chk("self_test", 11'(1'b0), 11'(self_test_enable));
    host.wr(SYS_CTRL_ONE_ADDR, 8'h01);
    gap = 0;
    while (boot_busy !== 1'b0 && gap < 50) begin
      gap++;
      @(negedge ref_clk);
    end
    chk("boot_busy", 11'(1'b0), 11'(boot_busy));
    // Boot lasts BT cycles, two of them spent in the refused write
    chk("boot_len", 11'(BT - 2), 11'(gap));
    host.rd(SYS_CTRL_ONE_ADDR, d);
    chk("ctrl_one", 11'(8'h00), 11'(d));
    host.rd(SYS_CTRL_TWO_ADDR, d);
    chk("ctrl_two", 11'(8'h00), 11'(d));
    chk("os_ratio", 11'(2), os_ratio);
    final_report();
  end
endmodule // tb_accel_system_control_regs
